// ### logic/vpiu_defines.svh
`ifndef VPIU_DEFINES_SVH
`define VPIU_DEFINES_SVH
// Functional notes
// - Eight active-low request inputs; a low level is a pending request.
// - Requests pass pulse-catching latches or bypass them into request reg.
// - Eight-bit mask register, one enable bit per level.
// - Requests ANDed with mask feed encoder giving highest level number.
// - Six mask operations: read, load, bit set, bit clear, set, clear.
// - Status is lowest accepted level; request raised when vector >= status.
// - Vector read loads status with vector plus one, below level seven.
// - Status can be loaded from or read out on its pins anytime.
// - Group advance send and receive move threshold between units.
// - Ripple and parallel disable let higher units inhibit lower ones.
// - Overflow output set when level seven is read.
// - Sixteen microinstructions control mask, status, vector, clearing.
// - Units cascade in groups of eight; one holds lowest group.
// - Instruction lines act only while the gate input is low.
// - Bypass low makes latches catch low pulses; high makes them transparent.
// - All registers and flags update on rising clock edge.
// - Read vector held in three-bit register, selects bit to clear.

// Microinstruction codes
`define OP_MASTER_CLR   4'h0
`define OP_CLR_ALL_REQ  4'h1
`define OP_CLR_REQ_BUS  4'h2
`define OP_CLR_REQ_LAST 4'h3
`define OP_READ_VECTOR  4'h4
`define OP_READ_STATUS  4'h5
`define OP_LOAD_STATUS  4'h6
`define OP_READ_MASK    4'h7
`define OP_LOAD_MASK    4'h8
`define OP_SET_MASK_BUS 4'h9
`define OP_CLR_MASK_BUS 4'ha
`define OP_SET_MASK_ALL 4'hb
`define OP_CLR_MASK_ALL 4'hc
`define OP_DIS_IRQ      4'hd
`define OP_EN_IRQ       4'he
`define OP_NOP          4'hf

// Register byte offsets
`define REG_CTRL    5'h00
`define REG_MASK    5'h04
`define REG_STATUS  5'h08
`define REG_VECTOR  5'h0c
`define REG_REQ     5'h10
`define REG_FLAGS   5'h14

// Field positions and reset values
`define CTRL_BYPASS_BIT 0
`define CTRL_IRQEN_BIT  1
`define MASK_RESET      8'h00
`define STATUS_RESET    3'h0
`define STATUS_TOP      3'h7
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ### logic/vpiu_pkg.sv
`include "vpiu_defines.svh"
package vpiu_pkg;
  // Microinstruction set
  typedef enum logic [3:0] {
    OP_MASTER_CLR   = `OP_MASTER_CLR,
    OP_CLR_ALL_REQ  = `OP_CLR_ALL_REQ,
    OP_CLR_REQ_BUS  = `OP_CLR_REQ_BUS,
    OP_CLR_REQ_LAST = `OP_CLR_REQ_LAST,
    OP_READ_VECTOR  = `OP_READ_VECTOR,
    OP_READ_STATUS  = `OP_READ_STATUS,
    OP_LOAD_STATUS  = `OP_LOAD_STATUS,
    OP_READ_MASK    = `OP_READ_MASK,
    OP_LOAD_MASK    = `OP_LOAD_MASK,
    OP_SET_MASK_BUS = `OP_SET_MASK_BUS,
    OP_CLR_MASK_BUS = `OP_CLR_MASK_BUS,
    OP_SET_MASK_ALL = `OP_SET_MASK_ALL,
    OP_CLR_MASK_ALL = `OP_CLR_MASK_ALL,
    OP_DIS_IRQ      = `OP_DIS_IRQ,
    OP_EN_IRQ       = `OP_EN_IRQ,
    OP_NOP          = `OP_NOP
  } op_t;
  typedef logic [2:0] level_t;
endpackage : vpiu_pkg

// ### logic/vpiu_if.sv
`timescale 1ns/1ps
// Request path between control and capture stage
interface vpiu_if;
  logic [7:0] reqN;    // Raw active-low requests
  logic [7:0] clr;     // Per-level clear strobes
  logic       bypass;  // Latch bypass
  logic [7:0] req;     // Stored requests
  modport ctrl (output reqN, clr, bypass, input req);
  modport cap  (input reqN, clr, bypass, output req);
endinterface : vpiu_if

// ### logic/req_capture.sv
`timescale 1ns/1ps
// Pulse latches and request register, one slice per level
module req_capture (
  input wire logic clk,    // Clock
  input wire logic rst_n,  // Sync reset, active low
  input wire logic ce,     // Clock enable
  vpiu_if.cap      rq      // Request path
);
  logic [7:0] latch_ff;
  logic [7:0] req_ff;

  assign rq.req = req_ff;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_lvl
      wire active = ~rq.reqN[i];
      // Latch output, transparent when bypassed
      wire src = rq.bypass ? active : (latch_ff[i] | active);
      // Set term; a bypassed latch follows its line and keeps nothing
      wire held = (latch_ff[i] & ~rq.clr[i]) | active;
      // Catch a low pulse; new request beats a clear
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          latch_ff[i] <= 1'b0;
          req_ff[i]   <= 1'b0;
        end else if (ce) begin
          latch_ff[i] <= rq.bypass ? active : held;
          req_ff[i]   <= (src & ~rq.clr[i]) | active;
        end
      end
    end
  endgenerate
endmodule : req_capture

// ### logic/prio_encoder.sv
`timescale 1ns/1ps
// Mask gating and eight-to-three priority encoder
module prio_encoder (
  input  wire logic [7:0]            req,   // Stored requests
  input  wire logic [7:0]            mask,  // Level enables
  output vpiu_pkg::level_t           vec,   // Highest unmasked level
  output logic                       any    // Any unmasked request
);
  wire [7:0] live = req & mask;

  // Highest numbered live level wins
  always_comb begin
    vec = 3'h0;
    for (int k = 0; k < 8; k++) begin
      if (live[k]) begin
        vec = k[2:0];
      end
    end
  end

  assign any = |live;
endmodule : prio_encoder

// ### logic/vectored_priority_interrupt_unit.sv
`timescale 1ns/1ps
`include "vpiu_defines.svh"
// Eight-level vectored priority interrupt unit with AXI4-Lite access
module vectored_priority_interrupt_unit (
  input  wire logic        clk,              // 25 MHz clock
  input  wire logic        rst_n,            // Sync reset, active low
  input  wire logic        ce,               // Clock enable
  input  wire logic [7:0]  reqN,             // Requests, active low
  input  wire logic        latchBypass,      // Latch bypass pin
  input  wire logic [3:0]  instr,            // Microinstruction
  input  wire logic        microcodeGateN,   // Instruction gate, low
  input  wire logic [7:0]  dataIn,           // Mask and clear bus in
  input  wire logic [2:0]  statusIn,         // Status pins in
  input  wire logic        groupAdvRecv,     // Carry in from lower
  input  wire logic        rippleDisIn,      // Inhibit from higher
  output logic             irqReq,           // Interrupt request
  output logic [2:0]       vectorOut,        // Held vector
  output logic [2:0]       statusOut,        // Status pins out
  output logic [7:0]       busOut,           // Read-out data
  output logic             busOutValid,      // Read-out strobe
  output logic             groupAdvSend,     // Carry out to higher
  output logic             rippleDisOut,     // Inhibit to lower
  output logic             parallelDisOut,   // Own request present
  output logic             statusOvf,        // Status overflow
  input  wire logic [4:0]  awaddr,           // AXI write address
  input  wire logic        awvalid,          // AXI
  output logic             awready,          // AXI
  input  wire logic [31:0] wdata,            // AXI write data
  input  wire logic [3:0]  wstrb,            // AXI byte enables
  input  wire logic        wvalid,           // AXI
  output logic             wready,           // AXI
  output logic [1:0]       bresp,            // AXI
  output logic             bvalid,           // AXI
  input  wire logic        bready,           // AXI
  input  wire logic [4:0]  araddr,           // AXI read address
  input  wire logic        arvalid,          // AXI
  output logic             arready,          // AXI
  output logic [31:0]      rdata,            // AXI read data
  output logic [1:0]       rresp,            // AXI
  output logic             rvalid,           // AXI
  input  wire logic        rready            // AXI
);
  // State
  logic [7:0]       mask_ff;
  vpiu_pkg::level_t status_ff;
  vpiu_pkg::level_t vecHold_ff;
  logic             vecClrEn_ff;
  logic             ovf_ff;
  logic             irqEn_ff;
  logic             bypassReg_ff;
  logic             irq_ff;
  logic [7:0]       busOut_ff;
  logic             busOutValid_ff;
  logic             gaSend_ff;
  logic             ripOut_ff;
  logic             parOut_ff;
  // Bus slave state
  logic             awHave_ff;
  logic             wHave_ff;
  logic [4:0]       awAddr_ff;
  logic [31:0]      wData_ff;
  logic [3:0]       wStrb_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             rvalid_ff;
  logic [31:0]      rdata_ff;
  logic [1:0]       rresp_ff;
  logic             awready_ff;
  logic             wready_ff;
  logic             arready_ff;

  vpiu_pkg::level_t vec;
  logic             anyReq;
  vpiu_if           rq ();

  // Request capture and encoding
  assign rq.reqN   = reqN;
  assign rq.bypass = latchBypass | bypassReg_ff;

  req_capture u_cap (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .rq    (rq)
  );

  prio_encoder u_enc (
    .req  (rq.req),
    .mask (mask_ff),
    .vec  (vec),
    .any  (anyReq)
  );

  // Microinstruction decode, gated by instruction enable
  wire                gate = ~microcodeGateN;
  vpiu_pkg::op_t      op;
  assign op = vpiu_pkg::op_t'(instr);
  wire opMclr    = gate && op == vpiu_pkg::OP_MASTER_CLR;
  wire opClrAll  = gate && op == vpiu_pkg::OP_CLR_ALL_REQ;
  wire opClrBus  = gate && op == vpiu_pkg::OP_CLR_REQ_BUS;
  wire opClrLast = gate && op == vpiu_pkg::OP_CLR_REQ_LAST;
  wire opRdVec   = gate && op == vpiu_pkg::OP_READ_VECTOR;
  wire opRdStat  = gate && op == vpiu_pkg::OP_READ_STATUS;
  wire opLdStat  = gate && op == vpiu_pkg::OP_LOAD_STATUS;
  wire opRdMask  = gate && op == vpiu_pkg::OP_READ_MASK;
  wire opLdMask  = gate && op == vpiu_pkg::OP_LOAD_MASK;
  wire opSetBits = gate && op == vpiu_pkg::OP_SET_MASK_BUS;
  wire opClrBits = gate && op == vpiu_pkg::OP_CLR_MASK_BUS;
  wire opSetAll  = gate && op == vpiu_pkg::OP_SET_MASK_ALL;
  wire opClrMAll = gate && op == vpiu_pkg::OP_CLR_MASK_ALL;
  wire opDisIrq  = gate && op == vpiu_pkg::OP_DIS_IRQ;
  wire opEnIrq   = gate && op == vpiu_pkg::OP_EN_IRQ;
  wire opMaskAny = opLdMask | opSetBits | opClrBits | opSetAll | opClrMAll;

  // Bus write and read strobes
  wire wrFire  = awHave_ff && wHave_ff && !bvalid_ff;
  wire wrCtrl  = wrFire && awAddr_ff == `REG_CTRL && wStrb_ff[0];
  wire wrMask  = wrFire && awAddr_ff == `REG_MASK && wStrb_ff[0];
  wire wrStat  = wrFire && awAddr_ff == `REG_STATUS && wStrb_ff[0];
  wire wrReq   = wrFire && awAddr_ff == `REG_REQ && wStrb_ff[0];
  wire wrOk    = awAddr_ff == `REG_CTRL || awAddr_ff == `REG_MASK
              || awAddr_ff == `REG_STATUS || awAddr_ff == `REG_REQ;
  wire rdFire  = arvalid && arready_ff;
  wire rdVecBus = rdFire && araddr == `REG_VECTOR;

  // Vector read from either side advances status
  wire vecRead = opRdVec | rdVecBus;
  wire topRead = vecRead && vec == `STATUS_TOP;
  wire ldStat  = opLdStat | wrStat;

  // Mask next value; microinstruction beats bus write
  logic [7:0] nxt_mask;
  always_comb begin
    nxt_mask = mask_ff;
    if (opMclr) begin
      nxt_mask = `MASK_RESET;
    end else if (opLdMask) begin
      nxt_mask = dataIn;
    end else if (opSetBits) begin
      nxt_mask = mask_ff | dataIn;
    end else if (opClrBits) begin
      nxt_mask = mask_ff & ~dataIn;
    end else if (opSetAll) begin
      nxt_mask = 8'hff;
    end else if (opClrMAll) begin
      nxt_mask = 8'h00;
    end else if (wrMask) begin
      nxt_mask = wData_ff[7:0];
    end
  end

  // Status next value
  vpiu_pkg::level_t nxt_status;
  always_comb begin
    nxt_status = status_ff;
    if (opMclr || groupAdvRecv) begin
      nxt_status = `STATUS_RESET;
    end else if (opLdStat) begin
      nxt_status = statusIn;
    end else if (wrStat) begin
      nxt_status = wData_ff[2:0];
    end else if (vecRead && anyReq && !topRead) begin
      nxt_status = vec + 3'h1;
    end
  end

  // Clear strobes for latches and request register
  wire [7:0] lastBit = 8'h01 << vecHold_ff;
  assign rq.clr = ({8{opMclr | opClrAll}})
                | ({8{opClrBus}} & dataIn)
                | ({8{opClrLast & vecClrEn_ff}} & lastBit)
                | ({8{wrReq}} & wData_ff[7:0]);

  // Accept and inhibit terms for the cascade
  wire accept  = anyReq && vec >= status_ff;
  wire nxtIrq  = accept && irqEn_ff && !rippleDisIn
              && !ovf_ff;

  // Mask, status, vector hold and flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_ff      <= `MASK_RESET;
      status_ff    <= `STATUS_RESET;
      vecHold_ff   <= 3'h0;
      vecClrEn_ff  <= 1'b0;
      irqEn_ff     <= 1'b1;
      bypassReg_ff <= 1'b0;
    end else if (ce) begin
      mask_ff   <= nxt_mask;
      status_ff <= nxt_status;
      if (vecRead) begin
        vecHold_ff  <= vec;
        vecClrEn_ff <= anyReq;
      end else if (opMclr) begin
        vecClrEn_ff <= 1'b0;
      end
      if (opMclr || opEnIrq) begin
        irqEn_ff <= 1'b1;
      end else if (opDisIrq) begin
        irqEn_ff <= 1'b0;
      end else if (wrCtrl) begin
        irqEn_ff <= wData_ff[`CTRL_IRQEN_BIT];
      end
      if (wrCtrl) begin
        bypassReg_ff <= wData_ff[`CTRL_BYPASS_BIT];
      end
    end
  end

  // Overflow flag: set by top-level read, set wins over reload
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovf_ff <= 1'b0;
    end else if (ce) begin
      if (topRead && anyReq) begin
        ovf_ff <= 1'b1;
      end else if (ldStat || opMclr || groupAdvRecv) begin
        ovf_ff <= 1'b0;
      end
    end
  end

  // Registered pin outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_ff         <= 1'b0;
      gaSend_ff      <= 1'b0;
      ripOut_ff      <= 1'b0;
      parOut_ff      <= 1'b0;
      busOut_ff      <= 8'h00;
      busOutValid_ff <= 1'b0;
    end else if (ce) begin
      irq_ff    <= nxtIrq;
      gaSend_ff <= topRead && anyReq;
      ripOut_ff <= rippleDisIn | (accept && !ovf_ff);
      parOut_ff <= accept && !ovf_ff;
      busOutValid_ff <= opRdVec | opRdStat | opRdMask;
      if (opRdVec) begin
        busOut_ff <= {5'h00, vec};
      end else if (opRdStat) begin
        busOut_ff <= {5'h00, status_ff};
      end else if (opRdMask) begin
        busOut_ff <= mask_ff;
      end
    end
  end

  assign irqReq         = irq_ff;
  assign vectorOut      = vecHold_ff;
  assign statusOut      = status_ff;
  assign busOut         = busOut_ff;
  assign busOutValid    = busOutValid_ff;
  assign groupAdvSend   = gaSend_ff;
  assign rippleDisOut   = ripOut_ff;
  assign parallelDisOut = parOut_ff;
  assign statusOvf      = ovf_ff;

  // Read data mux
  logic [31:0] rdMux;
  logic        rdHit;
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    case (araddr)
      `REG_CTRL:   rdMux = {30'h0, irqEn_ff, bypassReg_ff};
      `REG_MASK:   rdMux = {24'h0, mask_ff};
      `REG_STATUS: rdMux = {29'h0, status_ff};
      `REG_VECTOR: rdMux = {28'h0, anyReq, vec};
      `REG_REQ:    rdMux = {24'h0, rq.req};
      `REG_FLAGS:  rdMux = {24'h0, vecHold_ff, vecClrEn_ff,
                            ovf_ff, parOut_ff, irq_ff, anyReq};
      default:     rdHit = 1'b0;
    endcase
  end

  // Write channels, taken in either order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHave_ff  <= 1'b0;
      wHave_ff   <= 1'b0;
      awAddr_ff  <= 5'h00;
      wData_ff   <= 32'h0000_0000;
      wStrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `RESP_OKAY;
    end else if (ce) begin
      awready_ff <= !awHave_ff && !(awvalid && awready_ff);
      wready_ff  <= !wHave_ff && !(wvalid && wready_ff);
      if (awvalid && awready_ff) begin
        awHave_ff <= 1'b1;
        awAddr_ff <= awaddr;
      end else if (wrFire) begin
        awHave_ff <= 1'b0;
      end
      if (wvalid && wready_ff) begin
        wHave_ff <= 1'b1;
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end else if (wrFire) begin
        wHave_ff <= 1'b0;
      end
      if (wrFire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel, one outstanding read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `RESP_OKAY;
    end else if (ce) begin
      arready_ff <= !rvalid_ff && !rdFire;
      if (rdFire) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rdMux;
        rresp_ff  <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign awready = awready_ff;
  assign wready  = wready_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = arready_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;
endmodule : vectored_priority_interrupt_unit

// ### test/vectored_priority_interrupt_unit_props.sv
`timescale 1ns/1ps
// Port-level checks of the interrupt unit
module vpiu_props (
  input wire logic       clk,            // Clock
  input wire logic       rst_n,          // Sync reset, active low
  input wire logic       ce,             // Clock enable
  input wire logic [3:0] instr,          // Microinstruction
  input wire logic       microcodeGateN, // Instruction gate, low
  input wire logic [2:0] statusIn,       // Status pins in
  input wire logic       groupAdvRecv,   // Carry in
  input wire logic       rippleDisIn,    // Inhibit in
  input wire logic       arvalid,        // Bus read request
  input wire logic       irqReq,         // Interrupt request
  input wire logic [2:0] vectorOut,      // Held vector
  input wire logic [2:0] statusOut,      // Status pins out
  input wire logic       busOutValid,    // Read-out strobe
  input wire logic       groupAdvSend,   // Carry out
  input wire logic       rippleDisOut,   // Inhibit out
  input wire logic       statusOvf       // Overflow flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Read-out strobe follows a gated read only
  AST_MASK_READ: assert property ((ce && !microcodeGateN &&
    instr == vpiu_pkg::OP_READ_MASK) |=> busOutValid)
    else $error("mask read gave no strobe");
  AST_GATE_IDLE: assert property ((ce && microcodeGateN &&
    !arvalid) |=> !busOutValid)
    else $error("strobe while gate high");
  // Overflow and inhibit silence the request
  AST_OVF_QUIET: assert property (statusOvf && $past(statusOvf)
    |-> !irqReq)
    else $error("request during overflow");
  AST_RIPPLE_BLOCK: assert property ((ce && rippleDisIn) [*2]
    |=> !irqReq)
    else $error("request while inhibited");
  AST_RIPPLE_PASS: assert property ((ce && rippleDisIn)
    |=> rippleDisOut)
    else $error("inhibit not passed on");
  AST_TOP_SEND: assert property (groupAdvSend |-> vectorOut == 3'h7)
    else $error("carry out below top level");
  // Status register loads
  AST_CLEAR_ALL: assert property ((ce && !microcodeGateN &&
    instr == vpiu_pkg::OP_MASTER_CLR) |=> statusOut == 3'h0)
    else $error("master clear kept status");
  AST_GROUP_RECV: assert property ((ce && groupAdvRecv &&
    microcodeGateN) |=> statusOut == 3'h0)
    else $error("carry in kept status");
  AST_LOAD_STATUS: assert property ((ce && !microcodeGateN &&
    instr == vpiu_pkg::OP_LOAD_STATUS && !groupAdvRecv)
    |=> statusOut == $past(statusIn))
    else $error("status load wrong");
endmodule : vpiu_props

bind vectored_priority_interrupt_unit vpiu_props props0 (
  .clk(clk), .rst_n(rst_n), .ce(ce), .instr(instr),
  .microcodeGateN(microcodeGateN), .statusIn(statusIn),
  .groupAdvRecv(groupAdvRecv), .rippleDisIn(rippleDisIn),
  .arvalid(arvalid), .irqReq(irqReq), .vectorOut(vectorOut),
  .statusOut(statusOut), .busOutValid(busOutValid),
  .groupAdvSend(groupAdvSend), .rippleDisOut(rippleDisOut),
  .statusOvf(statusOvf)
);

// ### test/irq_source_model.sv
`timescale 1ns/1ps
// Interrupt sources: held levels and short low pulses
module irq_source_model (
  input  wire logic       clk,    // Clock
  input  wire logic [7:0] hold,   // Level requests, high = request
  input  wire logic [7:0] glitch, // Pulse requests, one cycle
  output logic      [7:0] reqN    // Request lines, active low
);
  logic [7:0] pulseLow = 8'h00;

  // Low pulse one clock long, seen at exactly one edge
  always @(posedge clk) begin
    pulseLow <= glitch;
  end

  // Idle lines sit high
  assign reqN = ~(hold | pulseLow);
endmodule : irq_source_model

// ### test/vectored_priority_interrupt_unit_tb.sv
`timescale 1ns/1ps
module vectored_priority_interrupt_unit_tb;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        latchBypass = 1'h0, ce = 1'h1;
  logic [3:0]  instr = 4'hf;
  logic        microcodeGateN = 1'h1;
  logic [7:0]  dataIn = 8'h00, hold = 8'h00, glitch = 8'h00;
  logic [2:0]  statusIn = 3'h0;
  logic        groupAdvRecv = 1'h0, rippleDisIn = 1'h0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  reqN, busOut;
  logic [2:0]  vectorOut, statusOut;
  logic        irqReq, busOutValid, groupAdvSend, rippleDisOut;
  logic        parallelDisOut, statusOvf, awready, wready, bvalid;
  logic        arready, rvalid;
  int          n_errors = 0, checks = 0;
  // Mask op table: load, set bits, clear bits, clear all, set all
  logic [3:0]  mOp [5] = '{4'h8, 4'h9, 4'ha, 4'hc, 4'hb};
  logic [7:0]  mDat [5] = '{8'h0f, 8'hf0, 8'h81, 8'h00, 8'h00};
  logic [7:0]  mExp [5] = '{8'h0f, 8'hff, 8'h7e, 8'h00, 8'hff};

  always #20 clk = ~clk;

  vectored_priority_interrupt_unit dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reqN(reqN),
    .latchBypass(latchBypass), .instr(instr),
    .microcodeGateN(microcodeGateN), .dataIn(dataIn),
    .statusIn(statusIn), .groupAdvRecv(groupAdvRecv),
    .rippleDisIn(rippleDisIn), .irqReq(irqReq), .vectorOut(vectorOut),
    .statusOut(statusOut), .busOut(busOut), .busOutValid(busOutValid),
    .groupAdvSend(groupAdvSend), .rippleDisOut(rippleDisOut),
    .parallelDisOut(parallelDisOut), .statusOvf(statusOvf),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );

  irq_source_model src (
    .clk(clk), .hold(hold), .glitch(glitch), .reqN(reqN)
  );

  // Verdict and end of run
  task automatic test_done();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // One microinstruction, then gate high again
  task automatic uop(input logic [3:0] op, input logic [7:0] d,
                     input logic g = 1'h0);
    @(posedge clk);
    instr <= op;
    dataIn <= d;
    microcodeGateN <= g;
    @(posedge clk);
    instr <= 4'hf;
    microcodeGateN <= 1'h1;
    #1;
  endtask : uop

  task automatic mop(input logic [3:0] op, input logic [7:0] d,
                     input logic [7:0] e);
    uop(op, d);
    chk(busOut, e);
    chk(busOutValid, 1'h1);
  endtask : mop

  // Bus write, address and data offered together
  task automatic axwc(input logic [4:0] a, input logic [31:0] d,
                      input logic [1:0] er);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'h0;
        awvalid <= 1'h0;
      end
      if (w && wready) begin
        w = 1'h0;
        wvalid <= 1'h0;
      end
      if (bvalid) begin
        bready <= 1'h0;
        chk(bresp, er);
        return;
      end
    end
    n_errors++;
    test_done();
  endtask : axwc

  // Bus read with expected data and response
  task automatic axrc(input logic [4:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        rready <= 1'h0;
        chk(rdata, ed);
        chk(rresp, er);
        return;
      end
    end
    n_errors++;
    test_done();
  endtask : axrc

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    axrc(5'h00, 32'h2, 2'h0);
    axrc(5'h08, 32'h0, 2'h0);
    axrc(5'h18, 32'h0, 2'h2);
    axwc(5'h18, 32'h5, 2'h2);
    axwc(5'h04, 32'h3c, 2'h0);
    axrc(5'h04, 32'h3c, 2'h0);
    for (int k = 0; k < 5; k++) begin
      uop(mOp[k], mDat[k]);
      mop(4'h7, 8'h00, mExp[k]);
    end
    uop(4'h8, 8'h11, 1'h1);
    mop(4'h7, 8'h00, 8'hff);
    // Two levels pending, read and clear the higher
    uop(4'h1, 8'h00);
    @(posedge clk);
    hold <= 8'h28;
    cyc(3);
    chk(irqReq, 1'h1);
    chk(parallelDisOut, 1'h1);
    mop(4'h4, 8'h00, 8'h05);
    chk(statusOut, 3'h6);
    chk(vectorOut, 3'h5);
    @(posedge clk);
    hold <= 8'h08;
    statusIn <= 3'h3;
    uop(4'h3, 8'h00);
    cyc(3);
    chk(irqReq, 1'h0);
    axrc(5'h10, 32'h08, 2'h0);
    uop(4'h6, 8'h00);
    chk(statusOut, 3'h3);
    cyc(2);
    chk(irqReq, 1'h1);
    mop(4'h5, 8'h00, 8'h03);
    uop(4'ha, 8'h08);
    cyc(3);
    chk(irqReq, 1'h0);
    // Top level read, overflow, carry in
    @(posedge clk);
    hold <= 8'h00;
    uop(4'hb, 8'h00);
    uop(4'h1, 8'h00);
    @(posedge clk);
    glitch <= 8'h80;
    @(posedge clk);
    glitch <= 8'h00;
    cyc(3);
    chk(irqReq, 1'h1);
    mop(4'h4, 8'h00, 8'h07);
    chk(groupAdvSend, 1'h1);
    cyc(3);
    chk(statusOvf, 1'h1);
    chk(irqReq, 1'h0);
    @(posedge clk);
    groupAdvRecv <= 1'h1;
    @(posedge clk);
    groupAdvRecv <= 1'h0;
    cyc(2);
    chk(statusOut, 3'h0);
    chk(statusOvf, 1'h0);
    cyc(2);
    chk(irqReq, 1'h1);
    @(posedge clk);
    rippleDisIn <= 1'h1;
    cyc(3);
    chk(irqReq, 1'h0);
    chk(rippleDisOut, 1'h1);
    @(posedge clk);
    rippleDisIn <= 1'h0;
    uop(4'hd, 8'h00);
    cyc(3);
    chk(irqReq, 1'h0);
    uop(4'he, 8'h00);
    cyc(3);
    chk(irqReq, 1'h1);
    // Short pulses with and without the latches
    uop(4'h1, 8'h00);
    @(posedge clk);
    latchBypass <= 1'h1;
    glitch <= 8'h04;
    @(posedge clk);
    glitch <= 8'h00;
    cyc(1);
    axrc(5'h10, 32'h00, 2'h0);
    @(posedge clk);
    latchBypass <= 1'h0;
    glitch <= 8'h04;
    @(posedge clk);
    glitch <= 8'h00;
    cyc(1);
    axrc(5'h10, 32'h04, 2'h0);
    uop(4'h2, 8'h04);
    axrc(5'h10, 32'h00, 2'h0);
    // Status over the bus, idle op, master clear
    axwc(5'h08, 32'h2, 2'h0);
    cyc(1);
    chk(statusOut, 3'h2);
    uop(4'hf, 8'h00);
    chk(statusOut, 3'h2);
    // Clock enable low freezes state
    @(posedge clk);
    ce <= 1'h0;
    uop(4'h0, 8'h00);
    chk(statusOut, 3'h2);
    @(posedge clk);
    ce <= 1'h1;
    axwc(5'h00, 32'h1, 2'h0);
    axrc(5'h00, 32'h1, 2'h0);
    uop(4'h0, 8'h00);
    chk(statusOut, 3'h0);
    mop(4'h7, 8'h00, 8'h00);
    test_done();
  end

  // Watchdog
  initial begin
    #2000000;
    n_errors++;
    test_done();
  end
endmodule : vectored_priority_interrupt_unit_tb
